// ===== core/synth_cfg_pkg.sv
// constants for the synthesizer profile configuration bank
// assumes apb word access; register index times four is the byte address
package synth_cfg_pkg;

    // ---------------------------------------------------------------
    // register indices
    // ---------------------------------------------------------------
    localparam int unsigned IDX_CTRL_P1   = 'h8;
    localparam int unsigned IDX_DEV_FIRST = 'h9;
    localparam int unsigned IDX_DEV_LAST  = 'h10;
    localparam int unsigned IDX_FRAC_HI   = 'h11;
    localparam int unsigned IDX_NUM_LO    = 'h12;
    localparam int unsigned IDX_DEN_LO    = 'h13;
    localparam int unsigned IDX_INT_DIV   = 'h14;
    localparam int unsigned IDX_REF_DIV   = 'h15;
    localparam int unsigned IDX_FIRST     = IDX_CTRL_P1;
    localparam int unsigned NUM_REGS      = IDX_REF_DIV - IDX_FIRST + 1;
    localparam int unsigned NUM_DEV       = IDX_DEV_LAST - IDX_DEV_FIRST + 1;
    localparam int unsigned REG_W         = 16;

    // ---------------------------------------------------------------
    // reset values
    // ---------------------------------------------------------------
    localparam logic [15:0] RST_CTRL_P1 = 16'h0010;
    localparam logic [15:0] RST_INT_DIV = 16'h0028;
    localparam logic [15:0] RST_REF_DIV = 16'h0101;
    localparam logic [15:0] RST_ZERO    = 16'h0000;

    // ---------------------------------------------------------------
    // field positions
    // ---------------------------------------------------------------
    localparam int unsigned F_BYTE_HI_LSB   = 8;
    localparam int unsigned F_BYTE_LO_LSB   = 0;
    localparam int unsigned F_PRESCALE_BIT  = 15;
    localparam int unsigned F_ORDER_LSB     = 12;
    localparam int unsigned F_INTDIV_LSB    = 0;
    localparam int unsigned F_FSK_EN_BIT    = 10;
    localparam int unsigned F_EXTDIV_LSB    = 6;
    localparam int unsigned F_EXTSEL_BIT    = 5;
    localparam int unsigned F_TXPWR_LSB     = 0;

    // ---------------------------------------------------------------
    // decode values
    // ---------------------------------------------------------------
    localparam logic [2:0] PRESCALE_DIV_LO = 3'h2;
    localparam logic [2:0] PRESCALE_DIV_HI = 3'h4;
    localparam logic [2:0] ORDER_MAX       = 3'h4;
    localparam logic [1:0] WORD_ALIGN      = 2'h0;
    localparam logic [15:0] UPPER_ZERO     = 16'h0000;

endpackage : synth_cfg_pkg

// ===== core/synth_profile_config_regs.sv
// apb register bank for profile settings of a fractional-n synthesizer
// assumes a zero-wait apb master on the same clock; fields feed the datapath
//
// The APB interface to the registers was left to the implementer.
`timescale 1ns/1ps
module synth_profile_config_regs #(
    parameter int unsigned ADDR_W = 8
) (
    input  wire logic              clock,
    input  wire logic              rst,
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [ADDR_W-1:0] paddr,
    input  wire logic [31:0]       pwdata,
    output logic                   pready,
    output logic                   pslverr,
    output logic [31:0]            prdata,
    output logic [7:0]             ref_post_divider_p2,
    output logic [7:0]             ref_pre_divider_p2,
    output logic                   prescaler_select_p2,
    output logic [2:0]             prescaler_div_p2,
    output logic [2:0]             modulator_order_p2,
    output logic [11:0]            integer_divider_p2,
    output logic [23:0]            frac_denominator_p2,
    output logic [23:0]            frac_numerator_p2,
    output logic [16*8-1:0]        deviation_words_p1,
    output logic                   shift_keying_enable_p1,
    output logic [3:0]             ext_osc_out_divider_p1,
    output logic                   ext_osc_select_p1,
    output logic [4:0]             tx_output_power_p1
);

    localparam int unsigned NR = synth_cfg_pkg::NUM_REGS;
    localparam int unsigned RW = synth_cfg_pkg::REG_W;

    // ---------------------------------------------------------------
    // address decode
    // ---------------------------------------------------------------
    function automatic logic addr_hit(input logic [ADDR_W-1:0] a);
        logic [ADDR_W-3:0] w;
        w = a[ADDR_W-1:2];
        return (a[1:0] == synth_cfg_pkg::WORD_ALIGN)
            && (int'(w) >= synth_cfg_pkg::IDX_FIRST)
            && (int'(w) <= synth_cfg_pkg::IDX_REF_DIV);
    endfunction : addr_hit

    function automatic logic [3:0] addr_slot(input logic [ADDR_W-1:0] a);
        logic [ADDR_W-3:0] w;
        w = a[ADDR_W-1:2];
        return 4'(int'(w) - synth_cfg_pkg::IDX_FIRST);
    endfunction : addr_slot

    function automatic int unsigned slot_of(input int unsigned idx);
        return idx - synth_cfg_pkg::IDX_FIRST;
    endfunction : slot_of

    logic [RW-1:0] regs_q [NR];
    logic [31:0]   prdata_q;
    logic          hit;
    logic [3:0]    slot;
    logic          wr_acc;
    logic [RW-1:0] rd_word;

    assign hit    = addr_hit(paddr);
    assign slot   = addr_slot(paddr);
    assign wr_acc = psel && penable && pwrite;
    assign rd_word = hit ? regs_q[slot] : synth_cfg_pkg::RST_ZERO;

    // ---------------------------------------------------------------
    // apb handshake
    // ---------------------------------------------------------------
    assign pready  = 1'b1;
    assign pslverr = psel && penable && !hit;
    assign prdata  = prdata_q;

    // read data captured in setup so it stands through the access phase
    always_ff @(posedge clock) begin
        if (rst) begin
            prdata_q <= 32'h0000_0000;
        end else if (psel && !penable && !pwrite) begin
            prdata_q <= {synth_cfg_pkg::UPPER_ZERO, rd_word};
        end
    end

    // ---------------------------------------------------------------
    // register storage
    // ---------------------------------------------------------------
    function automatic logic [RW-1:0] reset_of(input int unsigned s);
        if (s == slot_of(synth_cfg_pkg::IDX_CTRL_P1)) begin
            return synth_cfg_pkg::RST_CTRL_P1;
        end
        if (s == slot_of(synth_cfg_pkg::IDX_INT_DIV)) begin
            return synth_cfg_pkg::RST_INT_DIV;
        end
        if (s == slot_of(synth_cfg_pkg::IDX_REF_DIV)) begin
            return synth_cfg_pkg::RST_REF_DIV;
        end
        return synth_cfg_pkg::RST_ZERO;
    endfunction : reset_of

    for (genvar g = 0; g < NR; g++) begin : g_reg
        always_ff @(posedge clock) begin
            if (rst) begin
                regs_q[g] <= reset_of(g);
            end else if (wr_acc && hit && (slot == 4'(g))) begin
                regs_q[g] <= pwdata[RW-1:0];
            end
        end
    end

    // ---------------------------------------------------------------
    // field outputs
    // ---------------------------------------------------------------
    localparam int unsigned S_CTRL = synth_cfg_pkg::IDX_CTRL_P1 - synth_cfg_pkg::IDX_FIRST;
    localparam int unsigned S_FHI  = synth_cfg_pkg::IDX_FRAC_HI - synth_cfg_pkg::IDX_FIRST;
    localparam int unsigned S_NUM  = synth_cfg_pkg::IDX_NUM_LO - synth_cfg_pkg::IDX_FIRST;
    localparam int unsigned S_DEN  = synth_cfg_pkg::IDX_DEN_LO - synth_cfg_pkg::IDX_FIRST;
    localparam int unsigned S_INT  = synth_cfg_pkg::IDX_INT_DIV - synth_cfg_pkg::IDX_FIRST;
    localparam int unsigned S_REF  = synth_cfg_pkg::IDX_REF_DIV - synth_cfg_pkg::IDX_FIRST;
    localparam int unsigned S_DEV  = synth_cfg_pkg::IDX_DEV_FIRST - synth_cfg_pkg::IDX_FIRST;

    logic [2:0] order_raw;

    assign ref_post_divider_p2 = regs_q[S_REF][synth_cfg_pkg::F_BYTE_HI_LSB +: 8];
    assign ref_pre_divider_p2  = regs_q[S_REF][synth_cfg_pkg::F_BYTE_LO_LSB +: 8];
    assign prescaler_select_p2 = regs_q[S_INT][synth_cfg_pkg::F_PRESCALE_BIT];
    assign prescaler_div_p2    = prescaler_select_p2 ? synth_cfg_pkg::PRESCALE_DIV_HI
                                                     : synth_cfg_pkg::PRESCALE_DIV_LO;
    assign order_raw           = regs_q[S_INT][synth_cfg_pkg::F_ORDER_LSB +: 3];
    assign modulator_order_p2  = order_raw[2] ? synth_cfg_pkg::ORDER_MAX : order_raw;
    assign integer_divider_p2  = regs_q[S_INT][synth_cfg_pkg::F_INTDIV_LSB +: 12];
    assign frac_denominator_p2 = {regs_q[S_FHI][synth_cfg_pkg::F_BYTE_HI_LSB +: 8],
                                  regs_q[S_DEN]};
    assign frac_numerator_p2   = {regs_q[S_FHI][synth_cfg_pkg::F_BYTE_LO_LSB +: 8],
                                  regs_q[S_NUM]};

    for (genvar d = 0; d < synth_cfg_pkg::NUM_DEV; d++) begin : g_dev
        assign deviation_words_p1[d*RW +: RW] = regs_q[S_DEV + d];
    end

    assign shift_keying_enable_p1 = regs_q[S_CTRL][synth_cfg_pkg::F_FSK_EN_BIT];
    assign ext_osc_out_divider_p1 = regs_q[S_CTRL][synth_cfg_pkg::F_EXTDIV_LSB +: 4];
    assign ext_osc_select_p1      = regs_q[S_CTRL][synth_cfg_pkg::F_EXTSEL_BIT];
    assign tx_output_power_p1     = regs_q[S_CTRL][synth_cfg_pkg::F_TXPWR_LSB +: 5];

    // ---------------------------------------------------------------
    // checks
    // ---------------------------------------------------------------
    logic [ADDR_W-1:0] a_ref;
    logic [ADDR_W-1:0] a_int;
    logic [ADDR_W-1:0] a_fhi;
    logic [ADDR_W-1:0] a_den;
    logic [ADDR_W-1:0] a_ctl;

    assign a_ref = ADDR_W'(synth_cfg_pkg::IDX_REF_DIV * 4);
    assign a_int = ADDR_W'(synth_cfg_pkg::IDX_INT_DIV * 4);
    assign a_fhi = ADDR_W'(synth_cfg_pkg::IDX_FRAC_HI * 4);
    assign a_den = ADDR_W'(synth_cfg_pkg::IDX_DEN_LO * 4);
    assign a_ctl = ADDR_W'(synth_cfg_pkg::IDX_CTRL_P1 * 4);

    sequence s_wr_to(logic [ADDR_W-1:0] a);
        wr_acc && (paddr == a);
    endsequence

    sequence s_rd_back;
        psel && !penable && !pwrite && hit && (paddr == $past(paddr)) ##1 penable;
    endsequence

    AST_POST_DIV_WRITE: assert property (@(posedge clock) disable iff (rst)
        s_wr_to(a_ref) |=> ref_post_divider_p2 == $past(pwdata[15:8]))
        else $error("post divider not stored");

    AST_PRESCALE_DECODE: assert property (@(posedge clock) disable iff (rst)
        s_wr_to(a_int) |=> prescaler_div_p2 == ($past(pwdata[15]) ? 3'h4 : 3'h2))
        else $error("prescaler decode wrong");

    AST_ORDER_CLAMP: assert property (@(posedge clock) disable iff (rst)
        s_wr_to(a_int) ##0 pwdata[14] |=> modulator_order_p2 == 3'h4 [*2])
        else $error("order code not clamped to fourth");

    AST_DEN_JOIN: assert property (@(posedge clock) disable iff (rst)
        s_wr_to(a_den) |=> frac_denominator_p2 ==
            {$past(frac_denominator_p2[23:16]), $past(pwdata[15:0])})
        else $error("denominator assembled wrong");

    AST_NUM_HIGH: assert property (@(posedge clock) disable iff (rst)
        s_wr_to(a_fhi) |=> frac_numerator_p2[23:16] == $past(pwdata[7:0])
            && frac_denominator_p2[23:16] == $past(pwdata[15:8]))
        else $error("fraction high bytes wrong");

    AST_DEV_RESET: assert property (@(posedge clock)
        rst |=> deviation_words_p1 == '0)
        else $error("deviation words not cleared");

    AST_CTRL_LAYOUT: assert property (@(posedge clock) disable iff (rst)
        s_wr_to(a_ctl) |=> shift_keying_enable_p1 == $past(pwdata[10])
            && ext_osc_out_divider_p1 == $past(pwdata[9:6])
            && ext_osc_select_p1 == $past(pwdata[5])
            && tx_output_power_p1 == $past(pwdata[4:0]))
        else $error("control word fields wrong");

    AST_INT_RESET: assert property (@(posedge clock)
        rst ##1 !rst |-> integer_divider_p2 == 12'd40 && modulator_order_p2 == 3'h0
            && prescaler_div_p2 == 3'h2)
        else $error("integer divider reset wrong");

    AST_REF_RESET: assert property (@(posedge clock)
        rst ##1 !rst |-> ref_post_divider_p2 == 8'h01 && ref_pre_divider_p2 == 8'h01)
        else $error("reference dividers reset wrong");

    AST_READ_BACK: assert property (@(posedge clock) disable iff (rst)
        wr_acc && hit ##1 s_rd_back |-> prdata == {16'h0000, $past(pwdata[15:0], 2)})
        else $error("read back differs from write");

    // ---------------------------------------------------------------
    // further checks: storage, reads, refusal
    // ---------------------------------------------------------------
    logic [ADDR_W-1:0] a_num;
    logic              off_map;
    logic [RW*NR-1:0]  flat_regs;

    assign a_num   = ADDR_W'(synth_cfg_pkg::IDX_NUM_LO * 4);
    assign off_map = (paddr[1:0] != synth_cfg_pkg::WORD_ALIGN)
                  || (paddr < a_ctl) || (paddr > a_ref);

    for (genvar f = 0; f < NR; f++) begin : g_flat
        assign flat_regs[f*RW +: RW] = regs_q[f];
    end

    sequence s_rd_setup(logic [ADDR_W-1:0] a);
        psel && !penable && !pwrite && (paddr == a);
    endsequence

    sequence s_rd_off;
        psel && !penable && !pwrite && off_map;
    endsequence

    sequence s_wr_off;
        wr_acc && off_map;
    endsequence

    AST_PRE_DIV_WRITE: assert property (@(posedge clock) disable iff (rst)
        s_wr_to(a_ref) |=> ref_pre_divider_p2 == $past(pwdata[7:0]))
        else $error("pre divider not stored");

    AST_INT_DIV_WRITE: assert property (@(posedge clock) disable iff (rst)
        s_wr_to(a_int) |=> integer_divider_p2 == $past(pwdata[11:0]))
        else $error("integer divider not stored");

    AST_PRESCALE_RAW: assert property (@(posedge clock) disable iff (rst)
        s_wr_to(a_int) |=> prescaler_select_p2 == $past(pwdata[15]))
        else $error("prescaler bit not stored");

    AST_PRESCALE_BY4: assert property (@(posedge clock) disable iff (rst)
        prescaler_select_p2 |-> prescaler_div_p2 == 3'h4)
        else $error("prescaler set but not dividing by four");

    AST_PRESCALE_BY2: assert property (@(posedge clock) disable iff (rst)
        !prescaler_select_p2 |-> prescaler_div_p2 == 3'h2)
        else $error("prescaler clear but not dividing by two");

    AST_ORDER_PASS: assert property (@(posedge clock) disable iff (rst)
        s_wr_to(a_int) ##0 !pwdata[14] |=> modulator_order_p2 == $past(pwdata[14:12]))
        else $error("order code below four altered");

    AST_NUM_JOIN: assert property (@(posedge clock) disable iff (rst)
        s_wr_to(a_num) |=> frac_numerator_p2 ==
            {$past(frac_numerator_p2[23:16]), $past(pwdata[15:0])})
        else $error("numerator assembled wrong");

    AST_ORDER_RANGE: assert property (@(posedge clock) disable iff (rst)
        modulator_order_p2 <= 3'h4)
        else $error("order above fourth");

    AST_CTRL_RESET: assert property (@(posedge clock)
        rst ##1 !rst |-> tx_output_power_p1 == 5'h10 && !shift_keying_enable_p1
            && ext_osc_out_divider_p1 == 4'h0 && !ext_osc_select_p1)
        else $error("control word reset wrong");

    AST_DEN_RESET: assert property (@(posedge clock)
        rst ##1 !rst |-> frac_denominator_p2 == 24'h00_0000)
        else $error("denominator reset wrong");

    AST_NUM_RESET: assert property (@(posedge clock)
        rst ##1 !rst |-> frac_numerator_p2 == 24'h00_0000)
        else $error("numerator reset wrong");

    AST_RD_REF: assert property (@(posedge clock) disable iff (rst)
        s_rd_setup(a_ref) |=> prdata == {16'h0000,
            $past(ref_post_divider_p2), $past(ref_pre_divider_p2)})
        else $error("reference dividers read wrong");

    AST_RD_INT: assert property (@(posedge clock) disable iff (rst)
        s_rd_setup(a_int) |=> prdata[15] == $past(prescaler_select_p2)
            && prdata[11:0] == $past(integer_divider_p2))
        else $error("integer divider read wrong");

    AST_RD_FRAC_HI: assert property (@(posedge clock) disable iff (rst)
        s_rd_setup(a_fhi) |=> prdata[15:0] ==
            {$past(frac_denominator_p2[23:16]), $past(frac_numerator_p2[23:16])})
        else $error("fraction high bytes read wrong");

    AST_RD_DEN: assert property (@(posedge clock) disable iff (rst)
        s_rd_setup(a_den) |=> prdata[15:0] == $past(frac_denominator_p2[15:0]))
        else $error("denominator low read wrong");

    AST_RD_NUM: assert property (@(posedge clock) disable iff (rst)
        s_rd_setup(a_num) |=> prdata[15:0] == $past(frac_numerator_p2[15:0]))
        else $error("numerator low read wrong");

    AST_RD_CTRL: assert property (@(posedge clock) disable iff (rst)
        s_rd_setup(a_ctl) |=> prdata[10:0] == {$past(shift_keying_enable_p1),
            $past(ext_osc_out_divider_p1), $past(ext_osc_select_p1),
            $past(tx_output_power_p1)})
        else $error("control word read wrong");

    AST_RD_UPPER: assert property (@(posedge clock) disable iff (rst)
        psel && !penable && !pwrite |=> prdata[31:16] == 16'h0000)
        else $error("read data upper half not zero");

    AST_RD_OFF_MAP: assert property (@(posedge clock) disable iff (rst)
        s_rd_off |=> prdata == 32'h0000_0000)
        else $error("unmapped read not zero");

    AST_ERR_FLAG: assert property (@(posedge clock) disable iff (rst)
        pslverr == (psel && penable && off_map))
        else $error("error flag wrong");

    AST_WR_OFF_MAP: assert property (@(posedge clock) disable iff (rst)
        s_wr_off |=> $stable(flat_regs))
        else $error("unmapped write changed storage");

    AST_STORE_HOLD: assert property (@(posedge clock) disable iff (rst)
        !wr_acc |=> $stable(flat_regs))
        else $error("storage changed without write");

    AST_PRDATA_HOLD: assert property (@(posedge clock) disable iff (rst)
        !(psel && !penable && !pwrite) |=> $stable(prdata))
        else $error("read data changed outside read setup");

    for (genvar k = 0; k < synth_cfg_pkg::NUM_DEV; k++) begin : g_dev_chk
        localparam logic [ADDR_W-1:0] A_DEV = ADDR_W'((synth_cfg_pkg::IDX_DEV_FIRST + k) * 4);

        AST_DEV_WRITE: assert property (@(posedge clock) disable iff (rst)
            s_wr_to(A_DEV) |=> deviation_words_p1[k*RW +: RW] == $past(pwdata[RW-1:0]))
            else $error("deviation word not stored");

        AST_DEV_READ: assert property (@(posedge clock) disable iff (rst)
            s_rd_setup(A_DEV) |=> prdata == {16'h0000, $past(deviation_words_p1[k*RW +: RW])})
            else $error("deviation word read wrong");
    end

endmodule : synth_profile_config_regs

// ===== verification/tb_synth_profile_config_regs.sv
// testbench for the profile configuration register bank
// assumes a zero-wait apb slave at byte address index*4, one 25 MHz clock
`timescale 1ns/1ps
module tb_synth_profile_config_regs;
    logic          clock   = 1'b0;
    logic          rst     = 1'b1;
    logic          psel    = 1'b0;
    logic          penable = 1'b0;
    logic          pwrite  = 1'b0;
    logic [7:0]    paddr   = 8'h00;
    logic [31:0]   pwdata  = 32'h0000_0000;
    logic          pready, pslverr, prescaler_select_p2, shift_keying_enable_p1;
    logic          ext_osc_select_p1;
    logic [31:0]   prdata;
    logic [7:0]    ref_post_divider_p2, ref_pre_divider_p2;
    logic [2:0]    prescaler_div_p2, modulator_order_p2;
    logic [11:0]   integer_divider_p2;
    logic [23:0]   frac_denominator_p2, frac_numerator_p2;
    logic [127:0]  deviation_words_p1;
    logic [3:0]    ext_osc_out_divider_p1;
    logic [4:0]    tx_output_power_p1;
    logic [15:0]   shadow [8:21];
    int            errors     = 0;
    int            n_compared = 0;

    always #20 clock = ~clock;

    synth_profile_config_regs #(.ADDR_W(8)) dut (
        .clock(clock), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pready(pready), .pslverr(pslverr),
        .prdata(prdata), .ref_post_divider_p2(ref_post_divider_p2),
        .ref_pre_divider_p2(ref_pre_divider_p2), .prescaler_select_p2(prescaler_select_p2),
        .prescaler_div_p2(prescaler_div_p2), .modulator_order_p2(modulator_order_p2),
        .integer_divider_p2(integer_divider_p2), .frac_denominator_p2(frac_denominator_p2),
        .frac_numerator_p2(frac_numerator_p2), .deviation_words_p1(deviation_words_p1),
        .shift_keying_enable_p1(shift_keying_enable_p1),
        .ext_osc_out_divider_p1(ext_osc_out_divider_p1),
        .ext_osc_select_p1(ext_osc_select_p1), .tx_output_power_p1(tx_output_power_p1));

    // ---------------------------------------------------------------
    // shared tasks
    // ---------------------------------------------------------------
    task automatic stop_test();
        $display("errors=%0d n_compared=%0d", errors, n_compared);
        if (errors == 0 && n_compared > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : stop_test

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            errors++;
            $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    task automatic wait_ready();
        int i;
        i = 0;
        do begin
            @(posedge clock);
            i++;
        end while (pready !== 1'b1 && i < 20);
        if (pready !== 1'b1) begin
            errors++;
            $display("mismatch t=%0t got=%h exp=%h", $time, pready, 1'b1);
            stop_test();
        end
    endtask : wait_ready

    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] r, output logic err);
        psel    <= 1'b1;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= d;
        @(posedge clock);
        penable <= 1'b1;
        wait_ready();
        r = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        @(posedge clock);
    endtask : apb

    // ---------------------------------------------------------------
    // scenarios
    // ---------------------------------------------------------------
    task automatic t_reset();
        logic [31:0] r;
        logic        e;
        for (int i = 8; i <= 21; i++) begin
            apb(1'b0, 8'(i * 4), 32'h0, r, e);
            chk(r, i == 8 ? 32'h10 : i == 20 ? 32'h28 : i == 21 ? 32'h101 : 32'h0);
        end
        chk(prescaler_div_p2, 32'h0000_0002);
        chk(modulator_order_p2, 32'h0000_0000);
        chk(integer_divider_p2, 32'h0000_0028);
        chk({ref_post_divider_p2, ref_pre_divider_p2}, 32'h0101);
    endtask : t_reset

    task automatic t_rw();
        logic [31:0] r;
        logic        e;
        logic [15:0] v;
        for (int i = 8; i <= 21; i++) begin
            v = 16'hA5C3 ^ 16'(i * 'h1111);
            if (i == 8) v[15:11] = 5'h00;
            if (i == 20) v[11:10] = 2'h0;
            if (i == 21) v[7:0] = 8'h01;
            shadow[i] = v;
            apb(1'b1, 8'(i * 4), {16'hFFFF, v}, r, e);
        end
        for (int i = 8; i <= 21; i++) begin
            apb(1'b0, 8'(i * 4), 32'h0, r, e);
            chk(r, {16'h0000, shadow[i]});
        end
        chk(ref_post_divider_p2, shadow[21][15:8]);
        chk(ref_pre_divider_p2, shadow[21][7:0]);
        chk(frac_denominator_p2, {shadow[17][15:8], shadow[19]});
        chk(frac_numerator_p2, {shadow[17][7:0], shadow[18]});
        for (int k = 0; k < 8; k++) chk(deviation_words_p1[16*k +: 16], shadow[9+k]);
        chk({shift_keying_enable_p1, ext_osc_out_divider_p1, ext_osc_select_p1,
             tx_output_power_p1}, shadow[8][10:0]);
    endtask : t_rw

    task automatic t_decode();
        logic [31:0] r;
        logic        e;
        logic [2:0]  c;
        for (int i = 0; i < 8; i++) begin
            c = 3'(i);
            apb(1'b1, 8'h50, {16'h0000, c[0], c, 12'h3FF}, r, e);
            chk({prescaler_select_p2, prescaler_div_p2}, {c[0], c[0] ? 3'h4 : 3'h2});
            chk(modulator_order_p2, c[2] ? 3'h4 : c);
            chk(integer_divider_p2, 12'h3FF);
        end
    endtask : t_decode

    task automatic t_refused();
        logic [31:0] r;
        logic        e;
        apb(1'b1, 8'h58, 32'h1234, r, e);
        chk(e, 1'b1);
        apb(1'b1, 8'h21, 32'h0000_0000, r, e);
        chk(e, 1'b1);
        apb(1'b0, 8'h58, 32'h0, r, e);
        chk(e, 1'b1);
        chk(r, 32'h0000_0000);
        apb(1'b0, 8'h20, 32'h0, r, e);
        chk(e, 1'b0);
        chk(r, {16'h0000, shadow[8]});
    endtask : t_refused

    task automatic t_pair();
        psel    <= 1'b1;
        pwrite  <= 1'b1;
        paddr   <= 8'h44;
        pwdata  <= 32'h0000_5A3C;
        @(posedge clock);
        penable <= 1'b1;
        wait_ready();
        pwrite  <= 1'b0;
        penable <= 1'b0;
        pwdata  <= 32'h0000_0000;
        @(posedge clock);
        penable <= 1'b1;
        wait_ready();
        chk(prdata, 32'h0000_5A3C);
        psel    <= 1'b0;
        penable <= 1'b0;
        @(posedge clock);
    endtask : t_pair

    task automatic t_rerun();
        logic [31:0] r;
        logic        e;
        apb(1'b1, 8'h24, 32'h0000_BEEF, r, e);
        apb(1'b1, 8'h50, 32'h0000_7123, r, e);
        apb(1'b1, 8'h54, 32'h0000_0302, r, e);
        chk(deviation_words_p1[15:0], 32'h0000_BEEF);
        rst <= 1'b1;
        repeat (2) @(posedge clock);
        rst <= 1'b0;
        @(posedge clock);
        chk(deviation_words_p1[15:0], 32'h0000_0000);
        chk(integer_divider_p2, 32'h0000_0028);
        chk(modulator_order_p2, 32'h0000_0000);
        chk(prescaler_div_p2, 32'h0000_0002);
        chk({ref_post_divider_p2, ref_pre_divider_p2}, 32'h0000_0101);
        chk(tx_output_power_p1, 32'h0000_0010);
        apb(1'b0, 8'h24, 32'h0, r, e);
        chk(r, 32'h0000_0000);
        apb(1'b0, 8'h50, 32'h0, r, e);
        chk(r, 32'h0000_0028);
    endtask : t_rerun

    initial begin
        repeat (10) @(posedge clock);
        rst <= 1'b0;
        @(posedge clock);
        t_reset();
        t_rw();
        t_decode();
        t_pair();
        t_refused();
        t_rerun();
        stop_test();
    end
endmodule : tb_synth_profile_config_regs
